// file: src/i2c_rac_pkg.sv
// Constants and types shared by the two-wire register access controller
// ===========================================================
package i2c_rac_pkg;
    // ===========================================================
    // Timing
    localparam int SETUP_NS = 1000;
    localparam int HOLD_NS = 1000;
    localparam int LINK_PERIOD_NS = 160;
    localparam logic [8:0] SETUP_CYC = 9'((SETUP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam logic [8:0] HOLD_CYC = 9'((HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam logic [8:0] ACK_EXTRA_CYC = 9'h002;
    // ===========================================================
    // Bus encodings
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] PULSES_PER_BYTE = 4'h9;
    localparam logic [2:0] REG_BYTE = 3'h1;
    localparam logic [2:0] WDATA_FIRST = 3'h2;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    // ===========================================================
    // Link state machine
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_START = 6'h02,
        ST_BIT = 6'h04,
        ST_GAP = 6'h08,
        ST_STOP = 6'h10,
        ST_DONE = 6'h20
    } lstate_t;
endpackage

// file: src/i2c_register_access_controller.sv
// Two-wire register write/read engine with a core-side request port
`timescale 1ns/1ps
module i2c_register_access_controller
    import i2c_rac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [6:0] req_addr,
    input wire logic [7:0] req_reg,
    input wire logic [31:0] req_wdata,
    input wire logic [1:0] req_len,
    input wire logic [7:0] req_div,
    output logic busy,
    output logic done,
    output logic nack,
    output logic [31:0] rd_data,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    // ===========================================================
    // Core side: request capture and completion
    logic busy_r, go_tgl_r, done_r, nack_r, rd_q;
    logic [6:0] addr_q;
    logic [7:0] reg_q, div_q;
    logic [31:0] wdata_q, rdata_r;
    logic [1:0] len_q;
    logic dn_s1_r, dn_s2_r, dn_s3_r;
    logic done_tgl_r, err_r;
    logic [31:0] rdata_l_r;
    wire take = req_valid && !busy_r;
    wire done_edge = dn_s2_r ^ dn_s3_r;

    assign req_ready = !busy_r;
    assign busy = busy_r;
    assign done = done_r;
    assign nack = nack_r;
    assign rd_data = rdata_r;
    // Open-drain pins only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Command words stay frozen while busy, so the link may read them as static
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            go_tgl_r <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 7'h00;
            reg_q <= 8'h00;
            div_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            len_q <= 2'h0;
        end else if (take) begin
            busy_r <= 1'b1;
            go_tgl_r <= ~go_tgl_r;
            rd_q <= req_read;
            addr_q <= req_addr;
            reg_q <= req_reg;
            div_q <= req_div;
            wdata_q <= req_wdata;
            len_q <= req_len;
        end else if (done_edge) begin
            busy_r <= 1'b0;
        end
    end

    // Done toggle from the link domain; results are stable once it lands
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dn_s1_r <= 1'b0;
            dn_s2_r <= 1'b0;
            dn_s3_r <= 1'b0;
            done_r <= 1'b0;
            nack_r <= 1'b0;
            rdata_r <= RDATA_RESET;
        end else begin
            dn_s1_r <= done_tgl_r;
            dn_s2_r <= dn_s1_r;
            dn_s3_r <= dn_s2_r;
            done_r <= done_edge;
            if (done_edge) begin
                nack_r <= err_r;
                rdata_r <= rdata_l_r;
            end
        end
    end

    // ===========================================================
    // Link side: reset release, synchronisers
    logic lrst1_r, lrst_n;
    logic go_s1_r, go_s2_r, go_s3_r;
    logic sda_s1_r, sda_s, scl_s1_r, scl_s;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst1_r <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst1_r <= 1'b1;
            lrst_n <= lrst1_r;
        end
    end

    // Pins and toggle pass two flops before any logic looks at them
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            go_s1_r <= 1'b0;
            go_s2_r <= 1'b0;
            go_s3_r <= 1'b0;
            sda_s1_r <= 1'b1;
            sda_s <= 1'b1;
            scl_s1_r <= 1'b1;
            scl_s <= 1'b1;
        end else begin
            go_s1_r <= go_tgl_r;
            go_s2_r <= go_s1_r;
            go_s3_r <= go_s2_r;
            sda_s1_r <= sda_i;
            sda_s <= sda_s1_r;
            scl_s1_r <= scl_i;
            scl_s <= scl_s1_r;
        end
    end

    // ===========================================================
    // Link side: byte sequencing decode
    lstate_t state_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [2:0] byte_r;
    logic seg_r, ack_hi_r, sda_oe_r, scl_oe_r;
    logic [7:0] rx_sh_r;
    logic [8:0] cnt_r;

    // Write data byte k of the request word, first byte in the low lane
    function automatic logic [7:0] wbyte(input logic [31:0] w, input logic [2:0] k);
        wbyte = w[{k[1:0], 3'b000} +: 8];
    endfunction

    wire go_edge = go_s2_r ^ go_s3_r;
    wire reading = seg_r && (byte_r != 3'h0);
    wire [2:0] wk = byte_r - WDATA_FIRST;
    wire [7:0] tx_byte = (byte_r == 3'h0) ? {addr_q, seg_r} :
                         (byte_r == REG_BYTE) ? reg_q : wbyte(wdata_q, wk);
    wire last_byte = seg_r ? (byte_r == {1'b0, len_q} + 3'h1) :
                     rd_q ? (byte_r == REG_BYTE) : (byte_r == {1'b0, len_q} + WDATA_FIRST);
    wire bit_val = tx_byte[~bit_r[2:0]];
    wire is_ack = (bit_r == ACK_BIT);
    // Controller acks every read byte but the last, which it leaves high
    wire data_drv = is_ack ? (reading && !last_byte) : (!reading && !bit_val);
    wire tick = (cnt_r == 9'h000);
    // Phase never shorter than the stability margin, whatever the divider says
    wire [8:0] base_len = ({1'b0, div_q} < SETUP_CYC) ? SETUP_CYC : {1'b0, div_q};
    wire [8:0] plen = (state_r == ST_BIT && is_ack && ph_r[1]) ? base_len + ACK_EXTRA_CYC : base_len;

    // Pin drive decode: a one means pull low
    logic sda_drv_nxt, scl_drv_nxt;
    assign sda_drv_nxt = (state_r == ST_START) ? (ph_r != 2'h0) :
                         (state_r == ST_BIT) ? ((ph_r == 2'h0) ? sda_oe_r : data_drv) :
                         (state_r == ST_GAP) ? sda_oe_r :
                         (state_r == ST_STOP) ? ((ph_r == 2'h0) ? sda_oe_r : (ph_r != 2'h3)) : 1'b0;
    assign scl_drv_nxt = (state_r == ST_BIT) ? (ph_r < 2'h2) :
                         (state_r == ST_GAP) ? 1'b1 :
                         (state_r == ST_STOP) ? (ph_r < 2'h2) : 1'b0;
    assign sda_oe = sda_oe_r;
    assign scl_oe = scl_oe_r;

    // Phase timer and registered pin drives
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            cnt_r <= 9'h000;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
        end else begin
            cnt_r <= (state_r == ST_IDLE || state_r == ST_DONE || tick) ? plen : cnt_r - 9'h001;
            sda_oe_r <= sda_drv_nxt;
            scl_oe_r <= scl_drv_nxt;
        end
    end

    // ===========================================================
    // Link side: transaction state machine
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_r <= ST_IDLE;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            byte_r <= 3'h0;
            seg_r <= DIR_WRITE;
            ack_hi_r <= 1'b0;
            rx_sh_r <= 8'h00;
            err_r <= 1'b0;
            done_tgl_r <= 1'b0;
            rdata_l_r <= RDATA_RESET;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (go_edge) begin
                        state_r <= ST_START;
                        ph_r <= 2'h0;
                        seg_r <= DIR_WRITE;
                        byte_r <= 3'h0;
                        err_r <= 1'b0;
                        rdata_l_r <= RDATA_RESET;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        ph_r <= (ph_r == 2'h1) ? 2'h0 : ph_r + 2'h1;
                        bit_r <= 4'h0;
                        if (ph_r == 2'h1) state_r <= ST_BIT;
                    end
                end
                ST_BIT: begin
                    if (tick) begin
                        ph_r <= ph_r + 2'h1;
                        // Sample at the end of phase 2, the first of the two clock-high phases, well past setup
                        if (ph_r == 2'h2) begin
                            if (is_ack) ack_hi_r <= sda_s;
                            else rx_sh_r <= {rx_sh_r[6:0], sda_s};
                        end
                        if (ph_r == 2'h3 && !is_ack) bit_r <= bit_r + 4'h1;
                        if (ph_r == 2'h3 && is_ack) begin
                            bit_r <= 4'h0;
                            if (reading) rdata_l_r <= {rdata_l_r[23:0], rx_sh_r};
                            if (!reading && ack_hi_r) begin
                                err_r <= 1'b1;
                                state_r <= ST_STOP;
                            end else if (last_byte) begin
                                state_r <= ST_STOP;
                            end else begin
                                byte_r <= byte_r + 3'h1;
                                state_r <= ST_GAP;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (tick) state_r <= ST_BIT;
                end
                ST_STOP: begin
                    if (tick) begin
                        ph_r <= ph_r + 2'h1;
                        if (ph_r == 2'h3) begin
                            if (!seg_r && rd_q && !err_r) begin
                                seg_r <= DIR_READ;
                                byte_r <= 3'h0;
                                state_r <= ST_START;
                            end else begin
                                state_r <= ST_DONE;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    done_tgl_r <= ~done_tgl_r;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ===========================================================
    // Checks: helper counters for margins and pulses
    logic [7:0] low_cnt_r, stab_cnt_r;
    logic [3:0] pulse_cnt_r;
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            low_cnt_r <= 8'h00;
            stab_cnt_r <= 8'h00;
            pulse_cnt_r <= 4'h0;
        end else begin
            low_cnt_r <= !scl_oe_r ? 8'h00 : (low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 8'h01;
            stab_cnt_r <= (sda_drv_nxt != sda_oe_r) ? 8'h00 :
                          (stab_cnt_r == 8'hFF) ? stab_cnt_r : stab_cnt_r + 8'h01;
            pulse_cnt_r <= (state_r == ST_START || state_r == ST_GAP) ? 4'h0 :
                           (scl_oe_r && !scl_drv_nxt) ? pulse_cnt_r + 4'h1 : pulse_cnt_r;
        end
    end

    start_cond_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $rose(sda_oe_r) && !scl_oe_r |-> $past(state_r) == ST_START)
        else $error("data fell with clock high outside START");
    stop_cond_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $fell(sda_oe_r) && !scl_oe_r && $past(state_r) != ST_IDLE |-> $past(state_r) == ST_STOP)
        else $error("data rose with clock high outside STOP");
    data_hold_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $changed(sda_oe_r) && scl_oe_r |-> low_cnt_r >= HOLD_CYC[7:0])
        else $error("data changed too soon after clock fell");
    data_setup_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $fell(scl_oe_r) && $past(state_r) == ST_BIT |-> stab_cnt_r >= SETUP_CYC[7:0])
        else $error("data changed too close to clock rise");
    read_release_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        state_r == ST_BIT && reading && !is_ack && ph_r == 2'h1 ##1 ph_r == 2'h1 |-> !sda_oe_r)
        else $error("controller drove data during a read byte");
    nine_pulses_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        state_r == ST_GAP && $past(state_r) == ST_BIT |-> pulse_cnt_r == PULSES_PER_BYTE)
        else $error("byte did not take nine clock pulses");
    dir_bit_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        state_r == ST_BIT && byte_r == 3'h0 && bit_r == 4'h7 && ph_r == 2'h2 |-> sda_oe_r == !seg_r)
        else $error("direction bit wrong");
    write_byte_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        state_r == ST_BIT && !seg_r && byte_r == REG_BYTE && !is_ack && ph_r == 2'h2
        |-> sda_oe_r == !reg_q[~bit_r[2:0]])
        else $error("register address bit wrong");
    nack_stop_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        state_r == ST_BIT && is_ack && ph_r == 2'h3 && tick && !reading && ack_hi_r
        |=> state_r == ST_STOP && err_r)
        else $error("missing ack did not end in STOP");
    two_byte_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $rose(state_r == ST_STOP) && !seg_r && rd_q && !err_r |-> byte_r == REG_BYTE)
        else $error("read setup was not two bytes");
    restart_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $fell(state_r == ST_STOP) && !$past(seg_r) && rd_q && !err_r |-> state_r == ST_START && seg_r)
        else $error("read phase did not restart");
    // Loop-back of our own clock drive; a held-high pin means a stuck-high line
    scl_drive_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        low_cnt_r == 8'h03 |-> !scl_s)
        else $error("clock pin did not follow the low drive");
endmodule // i2c_register_access_controller

// file: sim/i2c_target_model.sv
// Behavioural two-wire target with a byte-addressed register file
`timescale 1ns/1ps
module i2c_target_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe
);
    logic [7:0] mem [0:255];
    logic [7:0] sh, ptr, tx;
    int bitn, nbyte;
    logic act, rd, sending;
    assign sending = act && rd && nbyte > 0 && bitn < 8;
    // ===========================================================
    // Framing
    initial begin
        sda_oe = 1'b0;
        act = 1'b0;
        rd = 1'b0;
        bitn = 0;
        nbyte = 0;
        ptr = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 5 + 3);
        end
    end
    // START arms the shifter, STOP drops the transfer at once
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        rd = 1'b0;
        bitn = 0;
        nbyte = 0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        act = 1'b0;
        sda_oe = 1'b0;
    end
    // ===========================================================
    // Bit engine: sample on rise, change the drive only on the clock fall
    always @(posedge scl) begin
        if (act && bitn < 8) begin
            sh = {sh[6:0], sda};
            bitn++;
        end else if (act && bitn == 9 && rd && nbyte > 0 && sda) begin
            act = 1'b0;
        end
    end
    always @(negedge scl) begin
        if (!act) begin
            sda_oe = 1'b0;
        end else if (bitn == 8) begin
            bitn = 9;
            if (nbyte == 0) rd = sh[0];
            if (nbyte == 1 && !rd) ptr = sh;
            if (nbyte > 1 && !rd) begin
                mem[ptr] = sh;
                ptr = ptr + 8'h01;
            end
            act = !(nbyte == 0 && sh[7:1] != ADDR);
            sda_oe = act && !(rd && nbyte > 0);
        end else if (bitn == 9) begin
            bitn = 0;
            nbyte++;
            tx = mem[ptr];
            if (rd) ptr = ptr + 8'h01;
            sda_oe = rd && !tx[7];
        end else if (sending) begin
            sda_oe = !tx[3'(7 - bitn)];
        end
    end
endmodule // i2c_target_model

// file: sim/i2c_register_access_controller_tb_top.sv
// Self-checking bench: random register writes and reads against a target model
`timescale 1ns/1ps
module i2c_register_access_controller_tb_top;
    import i2c_rac_pkg::*;
    localparam logic [6:0] TGT = 7'h2A;
    logic core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
    logic req_valid = 1'b0, req_read = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_reg = 8'h00, req_div = 8'h00;
    logic [31:0] req_wdata = 32'h0000_0000, seed = 32'h0000_0056;
    logic [1:0] req_len = 2'h0;
    logic req_ready, busy, done, nack, scl_oe, sda_oe, tgt_oe, scl, sda, scl_o, sda_o;
    logic [31:0] rd_data;
    int failures = 0, n_checks = 0, n_start = 0, n_stop = 0, n_pulse = 0;
    realtime t_oe = 0, t_fall = 0;
    // Open-drain wires with pull-ups
    assign scl = !scl_oe;
    assign sda = !(sda_oe || tgt_oe);
    always #2.5 core_clk = ~core_clk;
    // Link clock offset so its edges never meet the core edges
    initial begin
        #1.3;
        forever #80 link_clk = ~link_clk;
    end
    i2c_register_access_controller i_dut (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
        .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr),
        .req_reg(req_reg), .req_wdata(req_wdata), .req_len(req_len), .req_div(req_div), .busy(busy),
        .done(done), .nack(nack), .rd_data(rd_data), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    i2c_target_model #(.ADDR(TGT)) i_tgt (.scl(scl), .sda(sda), .sda_oe(tgt_oe));
    // ===========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One request, held for one core cycle, then a bounded wait for completion
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] r, input logic [31:0] wd,
                        input logic [1:0] ln);
        int k;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_read = rd;
        req_addr = a;
        req_reg = r;
        req_wdata = wd;
        req_len = ln;
        // At or below the floor keeps the run short; the absent target runs above it
        req_div = (a == TGT) ? 8'(rnd() % 8) : 8'(rnd() % 2) + 8'h08;
        chk(req_ready, 1'b1);
        @(negedge core_clk);
        req_valid = 1'b0;
        chk(busy, 1'b1);
        chk(req_ready, 1'b0);
        n_start = 0;
        n_stop = 0;
        n_pulse = 0;
        k = 0;
        while (done !== 1'b1 && k < 60000) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 60000) begin
            failures++;
            summarize();
        end
        chk(busy, 1'b0);
        // Completion is a single-cycle pulse
        @(negedge core_clk);
        chk(done, 1'b0);
    endtask
    // ===========================================================
    // Wire watch: framing events, pulse count and data timing
    always @(negedge sda) if (scl === 1'b1) n_start++;
    always @(posedge sda) if (scl === 1'b1) n_stop++;
    always @(negedge scl) t_fall = $realtime;
    always @(posedge scl) begin
        n_pulse++;
        if (rst_n === 1'b1) chk(($realtime - t_oe) >= 1000.0, 1'b1);
        if (i_tgt.sending) chk(sda_oe, 1'b0);
    end
    always @(sda_oe) begin
        if (scl === 1'b0 && rst_n === 1'b1) chk(($realtime - t_fall) >= 1000.0, 1'b1);
        t_oe = $realtime;
    end
    // ===========================================================
    // Main sequence
    initial begin
        logic [7:0] r;
        logic [31:0] wd, e;
        // Held over link edges too, so both domains see the reset
        repeat (3) @(negedge link_clk);
        @(negedge core_clk);
        chk({req_ready, busy, done, nack, scl_oe, sda_oe}, 32'h20);
        chk(rd_data, 32'h0000_0000);
        rst_n = 1'b1;
        // Two-byte write into consecutive registers
        r = 8'(rnd());
        wd = rnd();
        xfer(1'b0, TGT, r, wd, 2'h1);
        chk(i_tgt.mem[r], wd[7:0]);
        chk(i_tgt.mem[8'(r + 1)], wd[15:8]);
        chk(n_start, 1);
        chk(n_stop, 1);
        chk(n_pulse, 37);
        chk(nack, 1'b0);
        chk(rd_data, 32'h0000_0000);
        // Two-byte read straddling written and untouched registers
        e = {16'h0000, wd[15:8], i_tgt.mem[8'(r + 2)]};
        xfer(1'b1, TGT, 8'(r + 1), rnd(), 2'h1);
        chk(rd_data, e);
        chk(n_start, 2);
        chk(n_stop, 2);
        chk(n_pulse, 47);
        chk(nack, 1'b0);
        chk({scl_o, sda_o}, 2'h0);
        // Absent target: address byte unanswered, four-byte write abandoned
        xfer(1'b0, TGT ^ 7'h01, 8'(rnd()), rnd(), 2'h3);
        chk(nack, 1'b1);
        chk(n_pulse, 10);
        chk(n_stop, 1);
        chk(rd_data, 32'h0000_0000);
        summarize();
    end
endmodule // i2c_register_access_controller_tb_top
